/* File: rtl/rsc_regs.svh */
// Notes on behaviour
// (R1) Bus reset returns state machines to idle and registers to defaults.
// (R2) At reset release the 29 strap pins load four config registers; open pins read 1.
// (R3) Strap capture never changes pixel data output behaviour outside reset.
// (R4) Bits 1-0 select bus: 01 local bus, 10 PCI; 00 and 11 reserved.
// (R5) Bits 3-2 select page mode: 00 1-cycle EDO, 10 2-cycle EDO.
// (R6) Bits 7-5 give memory size: 000 4 MB, 100 2 MB, others reserved.
// (R7) Memory size field stays software writable after reset.
// (R8) Local bus: bit 4 enables ROM; bit 10 picks 64 KB (0) or 32 KB (1).
// (R9) Local bus: bit 8 low disables everything except ROM accesses.
// (R10) Bit 11 high uses internal clocks; low takes external clocks, test only.
// (R11) Local bus: bit 12 enables palette write snooping responses.
// (R12) Bits 17-16 set CAS/OE adjust: 6.5, 5, 3.5 ns or none.
// (R13) Bit 18 sets RAS low 4.5/3.5 clocks; bit 19 precharge 3.5/2.5.
// (R14) Bit 25 places serial port at I/O E8H (0) or E2H (1).
// (R15) Bit 26 high decodes serial port only at memory offset FF20H.
// (R16) Bits 15-13 are a firmware field; bit 24 must be strapped 0.
// (R17) Bits 28-27 set write-enable delay of 3, 2, 1 or 0 units.
// (R18) Reset must be held active at least 1000 ns by the driver.
// (R19) Captured values hold until next reset release or a software write; reset assertion already loads the defaults here.
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

`define RSC_OFF_BUSMEM 8'h00
`define RSC_OFF_ROMCLK 8'h04
`define RSC_OFF_DRAM 8'h08
`define RSC_OFF_SERIAL 8'h0C
`define RSC_OFF_STATUS 8'h10

`define RSC_STRAP_IDLE 29'h1FFFFFFF
`define RSC_RST_CFG 8'hFF
`define RSC_RST_SERIAL 8'h1F
`define RSC_WMASK_BUSMEM 8'hFF
`define RSC_WMASK_ROMCLK 8'hE0
`define RSC_WMASK_DRAM 8'h0F
`define RSC_WMASK_SERIAL 8'h1E

`define RSC_ST_DONE 0
`define RSC_ST_B24 1
`define RSC_ST_BUSRES 2

`define RSC_BUS_VL 2'h1
`define RSC_BUS_PCI 2'h2
`define RSC_PAGE_2CYC 2'h2
`define RSC_MEM_4MB 3'h0
`define RSC_MEM_2MB 3'h4
`define RSC_B_ROM_EN 4
`define RSC_B_DEV_EN 0
`define RSC_B_ROM_32K 2
`define RSC_B_CLK_INT 3
`define RSC_B_SNOOP 4
`define RSC_B_RAS_LOW 2
`define RSC_B_RAS_PRE 3
`define RSC_B_RSVD0 0
`define RSC_B_IO_E2 1
`define RSC_B_MMIO 2

`define RSC_CAS_00 7'h41
`define RSC_CAS_01 7'h32
`define RSC_CAS_10 7'h23
`define RSC_CAS_11 7'h00
`define RSC_RAS_HALF_9 4'h9
`define RSC_RAS_HALF_7 4'h7
`define RSC_RAS_HALF_5 4'h5
`define RSC_SER_IO_E8 20'h000E8
`define RSC_SER_IO_E2 20'h000E2
`define RSC_SER_MMIO 16'hFF20

`define RSC_CLK_PERIOD_PS 5000
`define RSC_RST_MIN_NS 1000
`define RSC_RST_MIN_CYC ((`RSC_RST_MIN_NS * 1000 + `RSC_CLK_PERIOD_PS - 1) / `RSC_CLK_PERIOD_PS)

`endif

/* File: rtl/rsc_pkg.sv */
package rsc_pkg;

	typedef enum logic [1:0] {
		RSC_CAP_ARM0 = 2'b00,
		RSC_CAP_ARM1 = 2'b01,
		RSC_CAP_SETTLE = 2'b10,
		RSC_CAP_LOADED = 2'b11
	} rsc_cap_e;

	typedef logic [7:0] rsc_byte_t;

	typedef struct packed {
		rsc_cap_e cap;
		logic [28:0] sync1;
		logic [28:0] sync2;
		rsc_byte_t busmem;
		rsc_byte_t romclk;
		rsc_byte_t dram;
		rsc_byte_t serial;
		logic [31:0] rdata;
		logic err;
		logic [28:0] pd_out;
		logic pd_oe;
	} rsc_state_s;

endpackage

/* File: rtl/rsc_cfg_if.sv */
`timescale 1ns/1ps
interface rsc_cfg_if;
	logic clk;
	logic rst_n;
	rsc_pkg::rsc_byte_t busmem;
	rsc_pkg::rsc_byte_t romclk;
	rsc_pkg::rsc_byte_t dram;
	rsc_pkg::rsc_byte_t serial;
	logic bus_is_vl;
	logic bus_is_pci;
	logic edo_two_cycle;
	logic mem_size_4mb;
	logic mem_size_2mb;
	logic rom_access_en;
	logic rom_size_32k;
	logic dev_full_en;
	logic clk_internal_sel;
	logic dac_snoop_en;
	logic [6:0] cas_oe_adj_tenth_ns;
	logic [3:0] ras_low_half_mclk;
	logic [3:0] ras_pre_half_mclk;
	logic [19:0] serial_io_addr;
	logic serial_io_decode_en;
	logic serial_mmio_en;
	logic [15:0] serial_mmio_offset;
	logic [1:0] we_delay_units;
	logic [2:0] bios_scratch;

	modport src (output clk, rst_n, busmem, romclk, dram, serial,
		input bus_is_vl, bus_is_pci, edo_two_cycle, mem_size_4mb, mem_size_2mb,
		rom_access_en, rom_size_32k, dev_full_en, clk_internal_sel, dac_snoop_en,
		cas_oe_adj_tenth_ns, ras_low_half_mclk, ras_pre_half_mclk, serial_io_addr,
		serial_io_decode_en, serial_mmio_en, serial_mmio_offset, we_delay_units,
		bios_scratch);
	modport dec (input clk, rst_n, busmem, romclk, dram, serial,
		output bus_is_vl, bus_is_pci, edo_two_cycle, mem_size_4mb, mem_size_2mb,
		rom_access_en, rom_size_32k, dev_full_en, clk_internal_sel, dac_snoop_en,
		cas_oe_adj_tenth_ns, ras_low_half_mclk, ras_pre_half_mclk, serial_io_addr,
		serial_io_decode_en, serial_mmio_en, serial_mmio_offset, we_delay_units,
		bios_scratch);
endinterface

/* File: rtl/rsc_strap_decode.sv */
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_strap_decode (
	// captured configuration in, decoded controls out
	rsc_cfg_if.dec cfg
);
	logic vl;

	assign vl = (cfg.busmem[1:0] == `RSC_BUS_VL);
	assign cfg.bus_is_vl = vl; // see (R4)
	assign cfg.bus_is_pci = (cfg.busmem[1:0] == `RSC_BUS_PCI); // see (R4)
	assign cfg.edo_two_cycle = (cfg.busmem[3:2] == `RSC_PAGE_2CYC); // see (R5)
	assign cfg.mem_size_4mb = (cfg.busmem[7:5] == `RSC_MEM_4MB); // see (R6)
	assign cfg.mem_size_2mb = (cfg.busmem[7:5] == `RSC_MEM_2MB); // see (R6)
	// rom and enable straps only mean something on the local bus
	assign cfg.rom_access_en = !vl || cfg.busmem[`RSC_B_ROM_EN]; // see (R8)
	assign cfg.rom_size_32k = vl && cfg.romclk[`RSC_B_ROM_32K]; // see (R8)
	assign cfg.dev_full_en = !vl || cfg.romclk[`RSC_B_DEV_EN]; // see (R9)
	assign cfg.clk_internal_sel = cfg.romclk[`RSC_B_CLK_INT]; // see (R10)
	assign cfg.dac_snoop_en = vl && cfg.romclk[`RSC_B_SNOOP]; // see (R11)
	assign cfg.bios_scratch = cfg.romclk[7:5]; // see (R16)
	always_comb begin
		case (cfg.dram[1:0]) // see (R12)
			2'h0: cfg.cas_oe_adj_tenth_ns = `RSC_CAS_00;
			2'h1: cfg.cas_oe_adj_tenth_ns = `RSC_CAS_01;
			2'h2: cfg.cas_oe_adj_tenth_ns = `RSC_CAS_10;
			default: cfg.cas_oe_adj_tenth_ns = `RSC_CAS_11;
		endcase
	end
	assign cfg.ras_low_half_mclk = cfg.dram[`RSC_B_RAS_LOW] ? `RSC_RAS_HALF_7 : `RSC_RAS_HALF_9; // see (R13)
	assign cfg.ras_pre_half_mclk = cfg.dram[`RSC_B_RAS_PRE] ? `RSC_RAS_HALF_5 : `RSC_RAS_HALF_7; // see (R13)
	assign cfg.serial_io_addr = cfg.serial[`RSC_B_IO_E2] ? `RSC_SER_IO_E2 : `RSC_SER_IO_E8; // see (R14)
	assign cfg.serial_io_decode_en = !cfg.serial[`RSC_B_MMIO]; // see (R15)
	assign cfg.serial_mmio_en = cfg.serial[`RSC_B_MMIO]; // see (R15)
	assign cfg.serial_mmio_offset = `RSC_SER_MMIO;
	// code 00 is the longest delay, so the unit count is the inverted code
	assign cfg.we_delay_units = ~cfg.serial[4:3]; // see (R17)

	default clocking @(posedge cfg.clk); endclocking
	default disable iff (!cfg.rst_n);

	AST_ROM_GATE: assert property (cfg.bus_is_vl && !cfg.busmem[4] |-> !cfg.rom_access_en) // see (R8)
		else $error("rom access enabled while strapped off");
	AST_DEV_GATE: assert property (!cfg.dev_full_en |-> cfg.bus_is_vl && !cfg.romclk[0]) // see (R9)
		else $error("device disabled outside local bus");
	AST_SNOOP: assert property (cfg.dac_snoop_en |-> cfg.bus_is_vl && cfg.romclk[4]) // see (R11)
		else $error("snoop enabled without local bus strap");
	AST_CAS: assert property (cfg.dram[1:0] == 2'h2 |-> cfg.cas_oe_adj_tenth_ns == 7'h23) // see (R12)
		else $error("cas adjust wrong for code 10");
	AST_RAS: assert property (cfg.dram[3:2] == 2'h3 |-> cfg.ras_low_half_mclk == 4'h7 && cfg.ras_pre_half_mclk == 4'h5) // see (R13)
		else $error("ras timing wrong");
	AST_SERIAL: assert property (cfg.serial_mmio_en |-> !cfg.serial_io_decode_en) // see (R15)
		else $error("serial port decoded at both addresses");
	AST_WE: assert property (cfg.serial[4:3] == 2'h0 |-> cfg.we_delay_units == 2'h3) // see (R17)
		else $error("write enable delay wrong for code 00");
	AST_BUS: assert property (!(cfg.bus_is_vl && cfg.bus_is_pci)) // see (R4)
		else $error("both buses selected");
endmodule

/* File: rtl/rsc_strap_top.sv */
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_strap_top (
	// clock and bus reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// shared pixel data pins
	input wire logic [28:0] strap_pixel_pins_in,
	output logic [28:0] strap_pixel_pins_out,
	output logic strap_pixel_pins_oe,
	// pixel logic that owns the pins
	input wire logic [28:0] pix_out_data,
	input wire logic pix_out_en,
	// decoded configuration
	output logic bus_is_vl,
	output logic bus_is_pci,
	output logic edo_two_cycle,
	output logic mem_size_4mb,
	output logic mem_size_2mb,
	output logic rom_access_en,
	output logic rom_size_32k,
	output logic dev_full_en,
	output logic clk_internal_sel,
	output logic dac_snoop_en,
	output logic [6:0] cas_oe_adj_tenth_ns,
	output logic [3:0] ras_low_half_mclk,
	output logic [3:0] ras_pre_half_mclk,
	output logic [19:0] serial_io_addr,
	output logic serial_io_decode_en,
	output logic serial_mmio_en,
	output logic [15:0] serial_mmio_offset,
	output logic [1:0] we_delay_units,
	output logic [2:0] bios_scratch,
	output logic strap_done
);
	rsc_pkg::rsc_state_s st_reg;
	rsc_pkg::rsc_state_s st_next;
	logic setup;
	logic wr;
	rsc_cfg_if cfg();

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == `RSC_OFF_BUSMEM) || (a == `RSC_OFF_ROMCLK) ||
			(a == `RSC_OFF_DRAM) || (a == `RSC_OFF_SERIAL) ||
			(a == `RSC_OFF_STATUS);
	endfunction

	// only the masked bits take the written value
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] mask);
		merge = (old & ~mask) | (nw & mask);
	endfunction

	function automatic logic [31:0] rd_word(input logic [7:0] a,
		input rsc_pkg::rsc_state_s s);
		logic [31:0] w;
		w = 32'h00000000;
		case (a)
			`RSC_OFF_BUSMEM: w[7:0] = s.busmem;
			`RSC_OFF_ROMCLK: w[7:0] = s.romclk;
			`RSC_OFF_DRAM: w[7:0] = s.dram;
			`RSC_OFF_SERIAL: w[7:0] = s.serial;
			`RSC_OFF_STATUS: begin
				w[`RSC_ST_DONE] = (s.cap == rsc_pkg::RSC_CAP_LOADED);
				w[`RSC_ST_B24] = s.serial[`RSC_B_RSVD0]; // see (R16)
				w[`RSC_ST_BUSRES] = (s.busmem[1:0] != `RSC_BUS_VL) &&
					(s.busmem[1:0] != `RSC_BUS_PCI); // see (R4)
			end
			default: w = 32'h00000000;
		endcase
		rd_word = w;
	endfunction

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite && addr_ok(paddr);

	always_comb begin
		st_next = st_reg;
		// pin straps cross into the clock domain through two flops
		st_next.sync1 = strap_pixel_pins_in;
		st_next.sync2 = st_reg.sync1;
		// pixel path passes through one register stage; strap logic never gates it
		st_next.pd_out = pix_out_data; // see (R3)
		st_next.pd_oe = pix_out_en; // see (R3)
		if (setup) begin
			st_next.rdata = rd_word(paddr, st_reg);
			st_next.err = !addr_ok(paddr);
		end
		if (wr) begin
			case (paddr)
				`RSC_OFF_BUSMEM: st_next.busmem = merge(st_reg.busmem, pwdata[7:0],
					`RSC_WMASK_BUSMEM); // see (R7)
				`RSC_OFF_ROMCLK: st_next.romclk = merge(st_reg.romclk, pwdata[7:0],
					`RSC_WMASK_ROMCLK);
				`RSC_OFF_DRAM: st_next.dram = merge(st_reg.dram, pwdata[7:0],
					`RSC_WMASK_DRAM);
				`RSC_OFF_SERIAL: st_next.serial = merge(st_reg.serial, pwdata[7:0],
					`RSC_WMASK_SERIAL);
				default: st_next.busmem = st_reg.busmem;
			endcase
		end
		case (st_reg.cap)
			rsc_pkg::RSC_CAP_ARM0: st_next.cap = rsc_pkg::RSC_CAP_ARM1;
			rsc_pkg::RSC_CAP_ARM1: st_next.cap = rsc_pkg::RSC_CAP_SETTLE;
			rsc_pkg::RSC_CAP_SETTLE: begin
				// capture wins over a software write in the same cycle
				st_next.busmem = st_reg.sync2[7:0]; // see (R2)
				st_next.romclk = st_reg.sync2[15:8]; // see (R2)
				st_next.dram = st_reg.sync2[23:16]; // see (R2)
				st_next.serial = {3'h0, st_reg.sync2[28:24]}; // see (R2)
				st_next.cap = rsc_pkg::RSC_CAP_LOADED;
			end
			// loaded: only software writes change the registers
			rsc_pkg::RSC_CAP_LOADED: st_next.cap = rsc_pkg::RSC_CAP_LOADED; // see (R19)
			default: st_next.cap = rsc_pkg::RSC_CAP_ARM0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.cap <= rsc_pkg::RSC_CAP_ARM0; // see (R1)
			st_reg.sync1 <= `RSC_STRAP_IDLE;
			st_reg.sync2 <= `RSC_STRAP_IDLE;
			st_reg.busmem <= `RSC_RST_CFG; // see (R1)
			st_reg.romclk <= `RSC_RST_CFG;
			st_reg.dram <= `RSC_RST_CFG;
			st_reg.serial <= `RSC_RST_SERIAL;
			st_reg.rdata <= 32'h00000000;
			st_reg.err <= 1'b0;
			st_reg.pd_out <= 29'h00000000;
			st_reg.pd_oe <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// single-cycle access phase: no wait states
	assign pready = penable;
	assign prdata = st_reg.rdata;
	assign pslverr = psel && penable && st_reg.err;
	assign strap_pixel_pins_out = st_reg.pd_out;
	assign strap_pixel_pins_oe = st_reg.pd_oe;
	assign strap_done = (st_reg.cap == rsc_pkg::RSC_CAP_LOADED);

	assign cfg.clk = pclk;
	assign cfg.rst_n = presetn;
	assign cfg.busmem = st_reg.busmem;
	assign cfg.romclk = st_reg.romclk;
	assign cfg.dram = st_reg.dram;
	assign cfg.serial = st_reg.serial;

	rsc_strap_decode u_decode (
		.cfg(cfg.dec)
	);

	assign bus_is_vl = cfg.bus_is_vl;
	assign bus_is_pci = cfg.bus_is_pci;
	assign edo_two_cycle = cfg.edo_two_cycle;
	assign mem_size_4mb = cfg.mem_size_4mb;
	assign mem_size_2mb = cfg.mem_size_2mb;
	assign rom_access_en = cfg.rom_access_en;
	assign rom_size_32k = cfg.rom_size_32k;
	assign dev_full_en = cfg.dev_full_en;
	assign clk_internal_sel = cfg.clk_internal_sel;
	assign dac_snoop_en = cfg.dac_snoop_en;
	assign cas_oe_adj_tenth_ns = cfg.cas_oe_adj_tenth_ns;
	assign ras_low_half_mclk = cfg.ras_low_half_mclk;
	assign ras_pre_half_mclk = cfg.ras_pre_half_mclk;
	assign serial_io_addr = cfg.serial_io_addr;
	assign serial_io_decode_en = cfg.serial_io_decode_en;
	assign serial_mmio_en = cfg.serial_mmio_en;
	assign serial_mmio_offset = cfg.serial_mmio_offset;
	assign we_delay_units = cfg.we_delay_units;
	assign bios_scratch = cfg.bios_scratch;

	// helper for the checks below
	logic seen_clk;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_clk <= 1'b0;
		end else begin
			seen_clk <= 1'b1;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_IDLE_AFTER_RESET: assert property (!seen_clk |-> st_reg.cap == rsc_pkg::RSC_CAP_ARM0 && st_reg.busmem == `RSC_RST_CFG) // see (R1)
		else $error("state not idle after reset");
	AST_CAPTURE_SEQ: assert property (st_reg.cap == rsc_pkg::RSC_CAP_ARM0 |-> ##3 strap_done) // see (R2)
		else $error("capture did not finish three cycles after release");
	AST_CAPTURE_PINS: assert property (st_reg.cap == rsc_pkg::RSC_CAP_SETTLE |=>
		st_reg.romclk == $past(strap_pixel_pins_in[15:8], 3) && st_reg.dram == $past(strap_pixel_pins_in[23:16], 3) &&
		st_reg.busmem == $past(strap_pixel_pins_in[7:0], 3)) // see (R2)
		else $error("captured strap differs from pins at release");
	AST_PIXEL_PASS: assert property (##1 1'b1 |-> strap_pixel_pins_out == $past(pix_out_data) &&
		strap_pixel_pins_oe == $past(pix_out_en)) // see (R3)
		else $error("pixel pin path disturbed");
	AST_MEMSIZE_WR: assert property (strap_done && wr && paddr == 8'h00 |=> st_reg.busmem[7:5] == $past(pwdata[7:5])) // see (R7)
		else $error("memory size field not written");
	AST_HOLD: assert property (strap_done && !wr |=> $stable(st_reg.busmem) && $stable(st_reg.romclk) &&
		$stable(st_reg.dram) && $stable(st_reg.serial)) // see (R19)
		else $error("captured strap changed without a write");
	AST_RO_BITS: assert property (strap_done && wr && paddr == 8'h04 |=> st_reg.romclk[4:0] == $past(st_reg.romclk[4:0])) // see (R19)
		else $error("read-only strap bits changed by write");
	AST_UNMAPPED: assert property (setup && !addr_ok(paddr) ##1 psel && penable |-> pslverr && pready) // see (R1)
		else $error("unmapped access not flagged");

	COV_CAPTURE: cover property (st_reg.cap == rsc_pkg::RSC_CAP_SETTLE ##1 strap_done);
	COV_MEMSIZE: cover property (strap_done && wr && paddr == 8'h00);
	COV_STATUS_RD: cover property (setup && !pwrite && paddr == 8'h10 ##1 pready);
	COV_ERR: cover property (pslverr);
endmodule

/* File: testbench/rsc_strap_board.sv */
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_strap_board (
	// clock and reset request
	input wire logic pclk,
	input wire logic go,
	// board pull-downs, one bit per pin
	input wire logic [28:0] strap_low,
	// device side of the shared pins
	input wire logic [28:0] pins_out,
	input wire logic pins_oe,
	// to the device
	output logic presetn,
	output logic [28:0] pins_in
);
	int cnt = 16;
	// released on the falling edge so the release never races the capture edge
	always @(negedge pclk) begin
		if (go) begin
			cnt <= `RSC_RST_MIN_CYC;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	assign presetn = (cnt == 0);
	// open pins read high; memory size pins may be left open
	assign pins_in = pins_oe ? pins_out : ~strap_low;
endmodule

/* File: testbench/reset_strap_config_capture_bench.sv */
`timescale 1ns/1ps
`include "rsc_regs.svh"
module reset_strap_config_capture_bench;
	logic pclk = 0;
	logic presetn, psel, penable, pwrite, pready, pslverr, go, pix_out_en, oe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic [28:0] pins_in, pins_out, strap_low, pix_out_data;
	logic [28:0] w;
	logic er, vl, pci, edo2, m4, m2, rom_en, rom32, dev_en, clk_int, snoop, io_en, mmio_en;
	logic done;
	logic [6:0] cas;
	logic [3:0] ras_low, ras_pre;
	logic [19:0] ser_addr;
	logic [15:0] mmio_off;
	logic [1:0] we;
	logic [2:0] scratch;
	int fail_count = 0;
	int check_count = 0;
	int m[4];
	int msk[4] = '{`RSC_WMASK_BUSMEM, `RSC_WMASK_ROMCLK, `RSC_WMASK_DRAM, `RSC_WMASK_SERIAL};
	always #2.5 pclk = ~pclk;
	rsc_strap_board u_board (.pclk(pclk), .go(go), .strap_low(strap_low), .pins_out(pins_out),
		.pins_oe(oe), .presetn(presetn), .pins_in(pins_in));
	rsc_strap_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .strap_pixel_pins_in(pins_in), .strap_pixel_pins_out(pins_out),
		.strap_pixel_pins_oe(oe), .pix_out_data(pix_out_data), .pix_out_en(pix_out_en),
		.bus_is_vl(vl), .bus_is_pci(pci), .edo_two_cycle(edo2), .mem_size_4mb(m4),
		.mem_size_2mb(m2), .rom_access_en(rom_en), .rom_size_32k(rom32), .dev_full_en(dev_en),
		.clk_internal_sel(clk_int), .dac_snoop_en(snoop), .cas_oe_adj_tenth_ns(cas),
		.ras_low_half_mclk(ras_low), .ras_pre_half_mclk(ras_pre), .serial_io_addr(ser_addr),
		.serial_io_decode_en(io_en), .serial_mmio_en(mmio_en), .serial_mmio_offset(mmio_off),
		.we_delay_units(we), .bios_scratch(scratch), .strap_done(done));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			fail_count++;
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic check_dec();
		logic [7:0] b, r, d, s;
		logic evl;
		b = m[0][7:0];
		r = m[1][7:0];
		d = m[2][7:0];
		s = m[3][7:0];
		evl = (b[1:0] == 2'h1);
		chk({vl, pci, edo2, m4, m2}, {evl, b[1:0] == 2'h2, b[3:2] == 2'h2, b[7:5] == 3'h0,
			b[7:5] == 3'h4}, "bus mem decode");
		chk({rom_en, rom32, dev_en, clk_int, snoop, scratch}, {!evl | b[4], evl & r[2],
			!evl | r[0], r[3], evl & r[4], r[7:5]}, "rom clock decode");
		chk({cas, ras_low, ras_pre}, {d[1:0] == 2'h0 ? 7'h41 : d[1:0] == 2'h1 ? 7'h32 :
			d[1:0] == 2'h2 ? 7'h23 : 7'h00, d[2] ? 4'h7 : 4'h9,
			d[3] ? 4'h5 : 4'h7}, "dram decode");
		chk({ser_addr, io_en, mmio_en, mmio_off, we}, {s[1] ? 20'h000E2 : 20'h000E8, !s[2],
			s[2], 16'hFF20, ~s[4:3]}, "serial decode");
	endtask

	task automatic check_regs();
		for (int a = 0; a < 4; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0);
			chk({er, rd}, {1'b0, 32'(m[a])}, "register read");
		end
		apb(1'b0, `RSC_OFF_STATUS, 32'h0);
		chk(rd[2:0], {m[0][1:0] == 2'h0 || m[0][1:0] == 2'h3, m[3][0], 1'b1}, "status");
		check_dec();
	endtask

	task automatic capture(input logic [28:0] word);
		int i;
		strap_low <= ~word;
		pix_out_en <= 0;
		// the pulse must span a falling edge for the board to see it
		@(posedge pclk);
		go <= 1;
		@(posedge pclk);
		go <= 0;
		m = '{`RSC_RST_CFG, `RSC_RST_CFG, `RSC_RST_CFG, `RSC_RST_SERIAL};
		repeat (20) @(posedge pclk);
		#1;
		chk(done, 1'b0, "done in reset");
		check_dec();
		for (i = 0; i < 400; i++) begin
			@(posedge pclk);
			if (done === 1'b1) break;
		end
		if (i == 400) begin
			fail_count++;
			print_verdict();
		end
		m = '{int'(word[7:0]), int'(word[15:8]), int'(word[23:16]), int'(word[28:24])};
		check_regs();
	endtask

	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		go = 0;
		strap_low = 0;
		pix_out_data = 0;
		pix_out_en = 0;
		void'($urandom(6345));
		capture(29'h1FFFFFFF);
		// every code of the bus, page, CAS and write-delay fields, memory size 4 MB and 2 MB, bit 24 set in the last pass only, random elsewhere
		for (int i = 0; i < 8; i++) begin
			w = 29'($urandom);
			w[1:0] = 2'(i);
			w[3:2] = 2'(i);
			w[7:5] = i[0] ? 3'h4 : 3'h0;
			w[17:16] = 2'(i);
			w[28:27] = 2'(i + 1);
			w[24] = (i == 7);
			capture(w);
			for (int a = 0; a < 4; a++) begin
				v = $urandom;
				apb(1'b1, 8'(a * 4), v);
				m[a] = (m[a] & ~msk[a] | v & msk[a]) & 32'hFF;
			end
			check_regs();
			apb(1'b1, 8'h14, $urandom);
			chk(er, 1'b1, "unmapped write");
			apb(1'b0, 8'h06, 32'h0);
			chk({er, rd}, {1'b1, 32'h0}, "misaligned read");
			for (int k = 0; k < 4; k++) begin
				v = $urandom;
				strap_low <= 29'($urandom);
				pix_out_data <= v[28:0];
				pix_out_en <= 1;
				@(posedge pclk);
				@(posedge pclk);
				#1;
				chk({oe, pins_out}, {1'b1, v[28:0]}, "pixel path");
			end
			pix_out_en <= 0;
			check_regs();
		end
		print_verdict();
	end
endmodule
